// ### bench/arnfh_filter_tb_top.sv
`timescale 1ns/100ps
module arnfh_filter_tb_top
    import arnfh_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic go = 0, remote = 0, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, shadow = '0;
    logic [5:0] node = '0;
    arnfh_ctx_t ctx = CTX_OTHER;
    arnfh_req_t req;
    arnfh_res_t res;
    int miscompares = 0, n_checks = 0, seed = 72, i;
    always #4 pclk = ~pclk;
    arnfh_node_model model (.pclk(pclk), .presetn(presetn), .go(go),
        .node(node), .remote(remote), .ctx(ctx), .req(req));
    arnfh_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
        .res(res));
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task chkres(input arnfh_res_t got, input arnfh_res_t exp);
        chk32({28'h0, got}, {28'h0, exp});
    endtask
    // one wait state expected, but the loop never assumes it
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        chk32(n, 32'h2);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task setclr(input logic clr, input logic [31:0] d);
        apb(1, clr ? OFF_FILTER_CLR : OFF_FILTER_SET, d);
        chk32({31'h0, err}, 32'h0);
        shadow = clr ? shadow & ~d : shadow | d;
        apb(0, OFF_FILTER_SET, 32'h0);
        chk32(rd, shadow);
        apb(0, OFF_FILTER_CLR, 32'h0);
        chk32(rd, shadow);
    endtask
    function automatic arnfh_res_t exp_res(input logic [5:0] nd,
        input logic rm, input arnfh_ctx_t c, input logic [31:0] f);
        if (c == CTX_OTHER)
            return 4'h9;
        if (rm)
            return {3'h7, f[31]};
        if (nd < 6'h20 || nd == 6'h3F)
            return 4'hC;
        return {3'h7, f[nd - 6'h20]};
    endfunction
    task send(input logic [5:0] nd, input logic rm, input arnfh_ctx_t c);
        arnfh_res_t e;
        e = exp_res(nd, rm, c, shadow);
        @(posedge pclk);
        go <= 1;
        node <= nd;
        remote <= rm;
        ctx <= c;
        @(posedge pclk);
        go <= 0;
        @(posedge pclk);
        @(negedge pclk);
        chkres(res, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop;
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, OFF_FILTER_SET, 32'h0);
        chk32(rd, FILTER_RESET);
        apb(0, OFF_FILTER_CLR, 32'h0);
        chk32(rd, FILTER_RESET);
        send(6'h24, 0, CTX_ASYNC_REQ);
        send(6'h05, 1, CTX_PHYS_REQ);
        $display("test reset done");
        apb(1, 12'h108, 32'hFFFFFFFF);
        chk32({31'h0, err}, 32'h1);
        chk32(rd, 32'h00000000);
        apb(0, 12'h102, 32'h0);
        chk32({31'h0, err}, 32'h1);
        chk32(rd, 32'h00000000);
        setclr(0, 32'hC0000010);
        send(6'h24, 0, CTX_ASYNC_REQ);
        send(6'h3E, 0, CTX_PHYS_REQ);
        send(6'h25, 0, CTX_ASYNC_REQ);
        send(6'h25, 1, CTX_ASYNC_REQ);
        send(6'h3F, 0, CTX_ASYNC_REQ);
        send(6'h25, 0, CTX_OTHER);
        $display("test corners done");
        for (i = 0; i < 40; i++)
        begin
            setclr(1'($random(seed)), $random(seed));
            repeat (3) send(6'($random(seed)), 1'($random(seed)),
                arnfh_ctx_t'(2'($unsigned($random(seed)) % 3)));
        end
        $display("test random done");
        report_and_stop;
    end
endmodule

// ### bench/arnfh_node_model.sv
`timescale 1ns/100ps
module arnfh_node_model
    import arnfh_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // packet command from the bench
    input wire logic go,
    input wire logic [5:0] node,
    input wire logic remote,
    input wire arnfh_ctx_t ctx,
    // request into the filter
    output arnfh_req_t req
);
    // idle header bits flip every cycle so a stale header never looks valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req <= '0;
        else if (go)
            req <= '{1'b1, node, !remote, ctx};
        else
            req <= '{1'b0, ~req.src_node, ~req.src_local,
                     arnfh_ctx_t'(~req.ctx)};
    end
endmodule

// ### hw/arnfh_filter.sv
`timescale 1ns/100ps
module arnfh_filter
    import arnfh_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive path
    input wire arnfh_req_t req,
    output arnfh_res_t res
);

    ////////////////////////////////////////////////////////////////////////

    logic [31:0] filter_ff;
    logic [31:0] nxt_filter;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic hit_set;
    logic hit_clr;
    logic done;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    assign hit_set = (paddr == OFF_FILTER_SET);
    assign hit_clr = (paddr == OFF_FILTER_CLR);
    // one wait state keeps pready and prdata straight from flops
    assign done = psel && penable && pready_ff;

    always_comb
    begin
        nxt_filter = filter_ff;
        nxt_pready = psel && penable && !pready_ff;
        nxt_prdata = 32'h00000000;
        nxt_pslverr = nxt_pready && !(hit_set || hit_clr);
        if (done && pwrite && hit_set)
        begin
            nxt_filter = filter_ff | pwdata;
        end
        else if (done && pwrite && hit_clr)
        begin
            nxt_filter = filter_ff & ~pwdata;
        end
        if (nxt_pready && !pwrite && (hit_set || hit_clr))
        begin
            nxt_prdata = filter_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filter_ff <= FILTER_RESET;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            filter_ff <= nxt_filter;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // the decision is a registered stage so ack logic sees a clean flop
    arnfh_match u_match
    (
        .pclk(pclk),
        .presetn(presetn),
        .filter(filter_ff),
        .req(req),
        .res(res)
    );

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic local_upper;
    logic node_bit;
    assign node_bit = filter_ff[req.src_node[4:0]];
    assign local_upper = req.valid && (req.ctx != CTX_OTHER)
        && req.src_local && arnfh_node_covered(req.src_node);

    property p_examine;
        req.valid && (req.ctx != CTX_OTHER) |=> res.valid && res.examined;
    endproperty
    a_examine: assert property (p_examine)
        else $error("request context not examined");

    property p_reject;
        local_upper && !filter_ff[req.src_node[4:0]] |=> !res.accept;
    endproperty
    a_reject: assert property (p_reject)
        else $error("node with clear bit accepted");

    property p_lower_uncovered;
        req.valid && (req.ctx != CTX_OTHER) && req.src_local
            && !arnfh_node_covered(req.src_node)
            |=> !res.covered && !res.accept;
    endproperty
    a_lower_uncovered: assert property (p_lower_uncovered)
        else $error("lower node decided by upper filter");

    property p_remote;
        req.valid && (req.ctx != CTX_OTHER) && !req.src_local
            |=> res.accept == $past(filter_ff[ALL_BUSES_BIT]);
    endproperty
    a_remote: assert property (p_remote)
        else $error("remote decision differs from bit 31");

    property p_node36;
        local_upper && (req.src_node == 6'h24) && filter_ff[4]
            |=> res.accept;
    endproperty
    a_node36: assert property (p_node36)
        else $error("node 36 not accepted with bit 4 set");

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready ##1 pready && !pslverr;
    endsequence
    property p_mapped_answer;
        s_setup ##1 psel && (hit_set || hit_clr) |-> s_access;
    endproperty
    a_mapped_answer: assert property (p_mapped_answer)
        else $error("mapped access not answered in one wait state");

    property p_read_back;
        done && !pwrite && (hit_set || hit_clr) |-> prdata == filter_ff;
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read does not return filter");

    property p_write_set;
        done && pwrite && hit_set
            |=> filter_ff == ($past(filter_ff) | $past(pwdata));
    endproperty
    a_write_set: assert property (p_write_set)
        else $error("set write wrong");

    property p_write_clr;
        done && pwrite && hit_clr
            |=> filter_ff == ($past(filter_ff) & ~$past(pwdata));
    endproperty
    a_write_clr: assert property (p_write_clr)
        else $error("clear write wrong");

    // other contexts pass through so the lower filter still sees them
    property p_pass_through;
        req.valid && (req.ctx == CTX_OTHER)
            |=> res.valid && !res.examined && !res.covered && res.accept;
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("non-request context not passed through");

    property p_idle_quiet;
        !req.valid |=> (res == '0);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("decision without a request");

    property p_upper_node;
        local_upper |=> res.covered && (res.accept == $past(node_bit));
    endproperty
    a_upper_node: assert property (p_upper_node)
        else $error("upper node decision differs from its bit");

    property p_unmapped_err;
        psel && penable && !pready && !(hit_set || hit_clr)
            |=> pready && pslverr && (prdata == 32'h00000000);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held longer than one cycle");

    // unmapped writes fall here too, so they must leave the filter alone
    property p_filter_quiet;
        !(done && pwrite && (hit_set || hit_clr)) |=> $stable(filter_ff);
    endproperty
    a_filter_quiet: assert property (p_filter_quiet)
        else $error("filter changed without a write");

    property p_prdata_idle;
        !pready |-> (prdata == 32'h00000000) && !pslverr;
    endproperty
    a_prdata_idle: assert property (p_prdata_idle)
        else $error("read data or error outside ready");

endmodule

// ### hw/arnfh_match.sv
`timescale 1ns/100ps
module arnfh_match
    import arnfh_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // filter state and request
    input wire logic [31:0] filter,
    input wire arnfh_req_t req,
    // registered decision
    output arnfh_res_t res
);

    arnfh_res_t res_ff;
    arnfh_res_t nxt_res;
    logic [4:0] bit_idx;

    assign res = res_ff;
    assign bit_idx = req.src_node[4:0];

    always_comb
    begin
        nxt_res = '0;
        nxt_res.valid = req.valid;
        // only requests bound for the two request contexts are checked
        nxt_res.examined = req.valid && (req.ctx != CTX_OTHER);
        // lower nodes belong to the low filter, so covered stays low
        nxt_res.covered = nxt_res.examined
            && (!req.src_local || arnfh_node_covered(req.src_node));
        if (!nxt_res.examined)
        begin
            nxt_res.accept = req.valid;
        end
        else if (!req.src_local)
        begin
            nxt_res.accept = filter[ALL_BUSES_BIT];
        end
        else if (nxt_res.covered)
        begin
            nxt_res.accept = filter[bit_idx];
        end
        else
        begin
            nxt_res.accept = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_ff <= '0;
        end
        else
        begin
            res_ff <= nxt_res;
        end
    end

endmodule

// ### hw/arnfh_pkg.sv
package arnfh_pkg;

    // register map, byte addresses on the apb side
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_FILTER_SET = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_FILTER_CLR = 12'h104;
    localparam logic [31:0] FILTER_RESET = 32'h00000000;

    // filter layout: bit 31 for remote buses, bits 30..0 for nodes 62..32
    localparam int ALL_BUSES_BIT = 31;
    localparam logic [5:0] NODE_BASE = 6'h20;
    localparam logic [5:0] NODE_BCAST = 6'h3F;

    // cycles from request strobe to decision strobe
    localparam int DECIDE_LATENCY = 1;

    // destination context of a received packet
    typedef enum logic [1:0] {
        CTX_OTHER = 2'h0,
        CTX_PHYS_REQ = 2'h1,
        CTX_ASYNC_REQ = 2'h2
    } arnfh_ctx_t;

    typedef struct packed {
        logic valid;
        logic [5:0] src_node;
        logic src_local;
        arnfh_ctx_t ctx;
    } arnfh_req_t;

    typedef struct packed {
        logic valid;
        logic examined;
        logic covered;
        logic accept;
    } arnfh_res_t;

    // local node number that this upper filter owns a bit for
    function automatic logic arnfh_node_covered(input logic [5:0] node);
        arnfh_node_covered = (node >= NODE_BASE) && (node != NODE_BCAST);
    endfunction

endpackage
